// >>> rtl/pmbus_bundle_status_readback.sv
// read-back logic for the telemetry bundle, status bundle and phase fault summary commands
// the link side runs on the pmbus front end clock; it holds command, write flag and data stable
// from a request until the answer returns, so those words cross under the toggle handshake
`default_nettype none

// Functional notes
// - telemetry bundle: status, vout, iout, temp, vin
// - duty-cycle and input-current slots read zero
// - disabled telemetry value reads zero
// - write to either bundle is invalid command
// - invalid command sets status byte cml bit
// - invalid command sets cml bit seven
// - invalid command raises the alert to host
// - status bundle: seven current status bytes ordered
// - status bundle write clears no status bit
// - broadcast phase selector returns per-phase fault bits
// - other selector below four returns that phase's fault word when assigned, else zero
// - phase numbers mapped per phase configuration
// - unassigned or disabled phase bits stay zero
// - bit n set means phase n faulted
module pmbus_bundle_status_readback (
	// core clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// link clock and reset
	input  wire logic         link_clk_in,
	input  wire logic         link_rst_n_in,
	// link side transaction request
	input  wire logic         req_in,
	input  wire logic [7:0]   cmd_code_in,
	input  wire logic         cmd_write_in,
	input  wire logic [15:0]  wr_data_in,
	output logic              req_ready_out,
	// link side answer
	output logic              resp_valid_out,
	output logic              resp_hit_out,
	output logic [3:0]        resp_len_out,
	output logic [111:0]      resp_data_out,
	// telemetry values and disables
	input  wire logic [15:0]  status_word_in,
	input  wire logic [15:0]  vout_in,
	input  wire logic [15:0]  iout_in,
	input  wire logic [15:0]  temp_in,
	input  wire logic [15:0]  vin_in,
	input  wire logic         vout_off_in,
	input  wire logic         iout_off_in,
	input  wire logic         vin_off_in,
	// status bytes
	input  wire logic [7:0]   status_vout_in,
	input  wire logic [7:0]   status_iout_in,
	input  wire logic [7:0]   status_input_in,
	input  wire logic [7:0]   status_temp_in,
	input  wire logic [6:0]   status_cml_in,
	input  wire logic [7:0]   status_other_in,
	input  wire logic [7:0]   status_mfr_in,
	input  wire logic         clear_faults_in,
	// phases
	input  wire logic [7:0]   phase_sel_in,
	input  wire logic [3:0]   phase_fault_in,
	input  wire logic [7:0]   phase_num_in,
	input  wire logic [3:0]   phase_enable_in,
	input  wire logic [63:0]  phase_word_in,
	// status and alert
	output logic [7:0]        status_cml_out,
	output logic [7:0]        status_byte_out,
	output logic [3:0]        phase_flags_out,
	output logic              smbalert_n_out
);
	typedef enum logic [1:0] {
		LK_IDLE = 2'b01,
		LK_WAIT = 2'b10
	} link_state_e;

	// link domain
	link_state_e   lk_state_r;
	logic          req_tog_r;
	logic          ack_seen_r;
	logic          ack_sync;
	// core domain
	logic          req_sync;
	logic          req_seen_r;
	logic          ack_tog_r;
	logic          ivc_r;
	logic [3:0]    ph_flags_r;
	logic [3:0]    ph_flags_nxt;
	logic [111:0]  resp_word_r;
	logic [3:0]    resp_len_r;
	logic          resp_hit_r;
	logic [111:0]  resp_word_nxt;
	logic [3:0]    resp_len_nxt;
	logic          resp_hit_nxt;
	logic          ivc_event;
	logic          take;
	logic          phase_all;
	logic [3:0]    fault_by_num;
	logic [3:0]    assigned;
	logic [7:0]    status_byte_now;

	// pass value through unless its telemetry is switched off
	function automatic logic [15:0] gate_value(input logic [15:0] v, input logic off);
		gate_value = off ? rb_pkg::ZERO_WORD : v;
	endfunction

	// link side: one request in flight at a time
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n_in) begin
			lk_state_r <= LK_IDLE;
			req_tog_r  <= 1'b0;
		end else begin
			unique case (lk_state_r)
				LK_IDLE: begin
					if (req_in) begin
						req_tog_r  <= ~req_tog_r;
						lk_state_r <= LK_WAIT;
					end
				end
				LK_WAIT: begin
					if (ack_sync != ack_seen_r) begin
						lk_state_r <= LK_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n_in) begin
			ack_seen_r <= 1'b0;
		end else begin
			ack_seen_r <= ack_sync;
		end
	end

	// ready registered; drops on the same link edge that accepts a request in LK_IDLE
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n_in) begin
			req_ready_out <= 1'b1;
		end else if (lk_state_r == LK_IDLE && req_in) begin
			req_ready_out <= 1'b0;
		end else if (lk_state_r == LK_WAIT && ack_sync != ack_seen_r) begin
			req_ready_out <= 1'b1;
		end
	end

	// core answer words are stable once the ack toggle is seen here
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n_in) begin
			resp_valid_out <= 1'b0;
			resp_hit_out   <= 1'b0;
			resp_len_out   <= rb_pkg::LEN_NONE;
			resp_data_out  <= rb_pkg::RST_RESP;
		end else begin
			resp_valid_out <= 1'b0;
			if (lk_state_r == LK_WAIT && ack_sync != ack_seen_r) begin
				resp_valid_out <= 1'b1;
				resp_hit_out   <= resp_hit_r;
				resp_len_out   <= resp_len_r;
				resp_data_out  <= resp_word_r;
			end
		end
	end

	bit_sync3 u_req_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d_in     (req_tog_r),
		.q_out    (req_sync)
	);

	bit_sync3 u_ack_sync (
		.clk_in   (link_clk_in),
		.rst_n_in (link_rst_n_in),
		.d_in     (ack_tog_r),
		.q_out    (ack_sync)
	);

	phase_map u_phase_map (
		.fault_in         (phase_fault_in),
		.num_in           (phase_num_in),
		.enable_in        (phase_enable_in),
		.fault_by_num_out (fault_by_num),
		.assigned_out     (assigned)
	);

	// core side: a new request is a settled change of the request toggle
	assign take      = (req_sync != req_seen_r);
	assign phase_all = (phase_sel_in == rb_pkg::PHASE_ALL_A) || (phase_sel_in == rb_pkg::PHASE_ALL_B);
	assign ivc_event = take && cmd_write_in &&
	                   (cmd_code_in == rb_pkg::CMD_TELEM || cmd_code_in == rb_pkg::CMD_STATUS);

	always_comb begin
		status_byte_now = status_word_in[7:0];
		status_byte_now[rb_pkg::BYTE_CML_BIT] = status_word_in[rb_pkg::BYTE_CML_BIT] | ivc_r | (|status_cml_in);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			req_seen_r <= 1'b0;
			ack_tog_r  <= 1'b0;
		end else begin
			req_seen_r <= req_sync;
			if (take) begin
				ack_tog_r <= ~ack_tog_r;
			end
		end
	end

	// invalid command flag; a new fault wins over a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ivc_r <= 1'b0;
		end else if (ivc_event) begin
			ivc_r <= 1'b1;
		end else if (clear_faults_in) begin
			ivc_r <= 1'b0;
		end
	end

	// phase flags latch; a write only clears bits and only with a broadcast selector
	always_comb begin
		ph_flags_nxt = ph_flags_r;
		if (take && cmd_write_in && cmd_code_in == rb_pkg::CMD_PHASE && phase_all) begin
			ph_flags_nxt = ph_flags_r & wr_data_in[3:0];
		end
		ph_flags_nxt = (ph_flags_nxt | fault_by_num) & assigned;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ph_flags_r <= rb_pkg::RST_PH_FLAGS;
		end else begin
			ph_flags_r <= ph_flags_nxt;
		end
	end

	// answer for the request being taken
	always_comb begin
		resp_word_nxt = rb_pkg::RST_RESP;
		resp_len_nxt  = rb_pkg::LEN_NONE;
		resp_hit_nxt  = 1'b0;
		if (!cmd_write_in) begin
			unique case (cmd_code_in)
				rb_pkg::CMD_TELEM: begin
					resp_hit_nxt  = 1'b1;
					resp_len_nxt  = rb_pkg::LEN_TELEM;
					resp_word_nxt = {rb_pkg::UNSUPPORTED,
					                 rb_pkg::UNSUPPORTED,
					                 gate_value(vin_in, vin_off_in),
					                 temp_in,
					                 gate_value(iout_in, iout_off_in),
					                 gate_value(vout_in, vout_off_in),
					                 status_word_in[15:8], status_byte_now};
				end
				rb_pkg::CMD_STATUS: begin
					resp_hit_nxt  = 1'b1;
					resp_len_nxt  = rb_pkg::LEN_STATUS;
					resp_word_nxt = {56'h0000, status_mfr_in, status_other_in, ivc_r, status_cml_in,
					                 status_temp_in, status_input_in, status_iout_in, status_vout_in};
				end
				rb_pkg::CMD_PHASE: begin
					resp_hit_nxt  = 1'b1;
					resp_len_nxt  = rb_pkg::LEN_PHASE;
					if (phase_all) begin
						resp_word_nxt = {108'h0000, ph_flags_r};
					end else if (phase_sel_in < 8'h04 && assigned[phase_sel_in[1:0]]) begin
						resp_word_nxt = {96'h0000, phase_word_in[16*phase_sel_in[1:0]+:16]};
					end
				end
				default: begin
					resp_hit_nxt = 1'b0;
				end
			endcase
		end else begin
			// writes are acknowledged with no data; bundle writes touch no status input
			resp_hit_nxt = (cmd_code_in == rb_pkg::CMD_PHASE) || ivc_event;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			resp_word_r <= rb_pkg::RST_RESP;
			resp_len_r  <= rb_pkg::LEN_NONE;
			resp_hit_r  <= 1'b0;
		end else if (take) begin
			resp_word_r <= resp_word_nxt;
			resp_len_r  <= resp_len_nxt;
			resp_hit_r  <= resp_hit_nxt;
		end
	end

	// registered status views and alert
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			status_cml_out  <= 8'h00;
			status_byte_out <= 8'h00;
			phase_flags_out <= rb_pkg::RST_PH_FLAGS;
			smbalert_n_out  <= 1'b1;
		end else begin
			status_cml_out  <= {ivc_r, status_cml_in};
			status_byte_out <= status_byte_now;
			phase_flags_out <= ph_flags_r;
			smbalert_n_out  <= ~ivc_r;
		end
	end
endmodule

`default_nettype wire

// >>> shared/rb_pkg.sv
// constants shared by the bundle read-back block: command codes, lengths, bit positions, reset values
// assumes a pmbus front end that decodes command codes and hands over one transaction at a time
`default_nettype none

package rb_pkg;
	// command codes
	localparam logic [7:0]   CMD_TELEM      = 8'hda;
	localparam logic [7:0]   CMD_STATUS     = 8'hdb;
	localparam logic [7:0]   CMD_PHASE      = 8'hdc;
	// answer lengths in bytes
	localparam logic [3:0]   LEN_TELEM      = 4'he;
	localparam logic [3:0]   LEN_STATUS     = 4'h7;
	localparam logic [3:0]   LEN_PHASE      = 4'h2;
	localparam logic [3:0]   LEN_NONE       = 4'h0;
	// phase selector values that mean all phases
	localparam logic [7:0]   PHASE_ALL_A    = 8'hff;
	localparam logic [7:0]   PHASE_ALL_B    = 8'h80;
	localparam int           NUM_PHASES     = 4;
	// bit positions
	localparam int           INVALID_CMD_BIT = 7;
	localparam int           BYTE_CML_BIT   = 1;
	// widths
	localparam int           TEL_W          = 112;
	localparam int           ST_W           = 56;
	// values after reset, and zero words for unsupported and disabled slots
	localparam logic [3:0]   RST_PH_FLAGS   = 4'h0;
	localparam logic [15:0]  UNSUPPORTED    = 16'h0000;
	localparam logic [15:0]  ZERO_WORD      = 16'h0000;
	localparam logic [111:0] RST_RESP       = 112'h0000;
endpackage

`default_nettype wire

// >>> rtl/bit_sync3.sv
// three-stage synchroniser for a single level from another clock domain
// the output moves only once the second and third stages agree
`default_nettype none

module bit_sync3 (
	// clock and reset of the receiving domain
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// level from the other domain
	input  wire logic d_in,
	// settled level
	output logic      q_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= d_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// first stage feeds the second stage only
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			q_out <= 1'b0;
		end else if (s2_r == s3_r) begin
			q_out <= s3_r;
		end
	end
endmodule

`default_nettype wire

// >>> rtl/phase_map.sv
// maps per-device fault levels onto phase-numbered summary bits
// assumes the phase configuration gives each device a two-bit number and an enable
`default_nettype none

module phase_map (
	// per device
	input  wire logic [3:0] fault_in,
	input  wire logic [7:0] num_in,
	input  wire logic [3:0] enable_in,
	// per phase number
	output logic      [3:0] fault_by_num_out,
	output logic      [3:0] assigned_out
);
	always_comb begin
		fault_by_num_out = 4'h0;
		assigned_out     = 4'h0;
		for (int p = 0; p < rb_pkg::NUM_PHASES; p++) begin
			if (enable_in[p]) begin
				assigned_out[num_in[2*p+:2]]     = 1'b1;
				fault_by_num_out[num_in[2*p+:2]] = fault_by_num_out[num_in[2*p+:2]] | fault_in[p];
			end
		end
	end
endmodule

`default_nettype wire

// >>> sim/rb_props.sv
// checker for the bundle read-back block, fed only by the block's own ports
// bound to every instance of pmbus_bundle_status_readback
`default_nettype none

module rb_props (
	// clocks and resets
	input wire logic         clk_in,
	input wire logic         rst_n_in,
	input wire logic         link_clk_in,
	input wire logic         link_rst_n_in,
	// link side
	input wire logic         req_in,
	input wire logic         req_ready_out,
	input wire logic         resp_valid_out,
	input wire logic [3:0]   resp_len_out,
	input wire logic [111:0] resp_data_out,
	// core side
	input wire logic         clear_faults_in,
	input wire logic [7:0]   phase_sel_in,
	input wire logic [3:0]   phase_fault_in,
	input wire logic [7:0]   phase_num_in,
	input wire logic [3:0]   phase_enable_in,
	input wire logic [7:0]   status_cml_out,
	input wire logic [7:0]   status_byte_out,
	input wire logic [3:0]   phase_flags_out,
	input wire logic         smbalert_n_out
);
	logic [3:0] asg;

	always_comb begin
		asg = 4'h0;
		for (int p = 0; p < 4; p++) begin
			if (phase_enable_in[p])
				asg[phase_num_in[2*p +: 2]] = 1'b1;
		end
	end

	property p_answer;
		@(posedge link_clk_in) disable iff (!link_rst_n_in)
		req_in && req_ready_out |=> !req_ready_out ##[1:30] resp_valid_out && req_ready_out;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer to a taken request");

	property p_tel_pad;
		@(posedge link_clk_in) disable iff (!link_rst_n_in)
		resp_valid_out && resp_len_out == 4'he |-> resp_data_out[111:80] == 32'h0000_0000;
	endproperty
	a_tel_pad: assert property (p_tel_pad) else $error("telemetry pad slots not zero");

	property p_st_pad;
		@(posedge link_clk_in) disable iff (!link_rst_n_in)
		resp_valid_out && resp_len_out == 4'h7 |-> resp_data_out[111:56] == 56'h0;
	endproperty
	a_st_pad: assert property (p_st_pad) else $error("status bundle longer than seven bytes");

	property p_ph_hi;
		@(posedge link_clk_in) disable iff (!link_rst_n_in)
		resp_valid_out && resp_len_out == 4'h2 && (phase_sel_in == 8'hff || phase_sel_in == 8'h80)
			|-> resp_data_out[111:4] == 108'h0;
	endproperty
	a_ph_hi: assert property (p_ph_hi) else $error("summary upper bits not zero");

	property p_alert;
		@(posedge clk_in) disable iff (!rst_n_in)
		smbalert_n_out == !status_cml_out[7];
	endproperty
	a_alert: assert property (p_alert) else $error("alert disagrees with invalid command flag");

	property p_summary;
		@(posedge clk_in) disable iff (!rst_n_in)
		status_cml_out[7] |-> status_byte_out[1];
	endproperty
	a_summary: assert property (p_summary) else $error("status byte misses comm fault");

	property p_sticky;
		@(posedge clk_in) disable iff (!rst_n_in)
		status_cml_out[7] && !clear_faults_in && !$past(clear_faults_in) |=> status_cml_out[7];
	endproperty
	a_sticky: assert property (p_sticky) else $error("invalid command flag dropped");

	property p_unasg;
		@(posedge clk_in) disable iff (!rst_n_in)
		asg == $past(asg) && asg == $past(asg, 2) |-> (phase_flags_out & ~asg) == 4'h0;
	endproperty
	a_unasg: assert property (p_unasg) else $error("unused phase bit set");

	property p_fault;
		@(posedge clk_in) disable iff (!rst_n_in)
		phase_fault_in[0] && phase_enable_in[0] |-> ##[1:2] phase_flags_out[phase_num_in[1:0]];
	endproperty
	a_fault: assert property (p_fault) else $error("fault not shown on its phase bit");
endmodule

bind pmbus_bundle_status_readback rb_props u_rb_props (.*);

`default_nettype wire

// >>> sim/rb_host.sv
// host model: one command at a time on the link side, answer collected at resp_valid_in
// assumes the bench runs the link clock; drives just after a rising link edge
`default_nettype none

module rb_host (
	// link clock and answer
	input  wire logic         link_clk_in,
	input  wire logic         req_ready_in,
	input  wire logic         resp_valid_in,
	input  wire logic [3:0]   resp_len_in,
	input  wire logic [111:0] resp_data_in,
	// request
	output logic              req_out,
	output logic [7:0]        cmd_out,
	output logic              write_out,
	output logic [15:0]       wdata_out
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		req_out = 1'b0;
		cmd_out = 8'h00;
		write_out = 1'b0;
		wdata_out = 16'h0000;
	end

	task automatic xfer(input logic [7:0] cmd, input logic wr, input logic [15:0] wd,
		output logic [3:0] len, output logic [111:0] data, output bit ok);
		int n;
		ok = 1'b0;
		n = 0;
		@(posedge link_clk_in);
		#1;
		cmd_out = cmd;
		write_out = wr;
		wdata_out = wd;
		req_out = 1'b1;
		do begin
			@(posedge link_clk_in);
			n++;
		end while (req_ready_in !== 1'b1 && n < 40);
		#1;
		req_out = 1'b0;
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge link_clk_in);
			if (resp_valid_in === 1'b1) begin
				ok = 1'b1;
				len = resp_len_in;
				data = resp_data_in;
			end
		end
		#1;
		// released lines must not keep the last value
		cmd_out = ~cmd;
		write_out = ~wr;
		wdata_out = ~wd;
	endtask
endmodule

`default_nettype wire

// >>> sim/test_pmbus_bundle_status_readback.sv
// self-checking bench for the bundle read-back block with a host model on the link side
// assumes core-side levels change only between transactions
`default_nettype none

module test_pmbus_bundle_status_readback;
	timeunit 1ns;
	timeprecision 100ps;
	logic         clk_in = 1'b0, rst_n_in = 1'b0, link_clk_in = 1'b0, link_rst_n_in = 1'b0;
	logic         req_in, cmd_write_in, req_ready_out, resp_valid_out, resp_hit_out, smbalert_n_out;
	logic         vout_off_in = 1'b0, iout_off_in = 1'b0, vin_off_in = 1'b0, clear_faults_in = 1'b0;
	logic [7:0]   cmd_code_in, status_cml_out, status_byte_out, phase_sel_in = 8'hff;
	logic [7:0]   phase_num_in = 8'h1e;
	logic [3:0]   phase_enable_in = 4'h7, phase_fault_in = 4'h0, phase_flags_out, resp_len_out, len;
	logic [15:0]  wr_data_in, status_word_in = 16'h0, vout_in = 16'h0, iout_in = 16'h0, temp_in = 16'h0;
	logic [15:0]  vin_in = 16'h0;
	logic [7:0]   status_vout_in = 8'h0, status_iout_in = 8'h0, status_input_in = 8'h0, status_temp_in = 8'h0;
	logic [7:0]   status_other_in = 8'h0, status_mfr_in = 8'h0;
	logic [6:0]   status_cml_in = 7'h0;
	logic [63:0]  phase_word_in = 64'h0;
	logic [111:0] resp_data_out, data, ex[4];
	logic [31:0]  seed = 32'h0001_0049;
	int           err_count = 0, n_tests = 0;
	bit           ok;

	always #5 clk_in = ~clk_in;
	always #7.5 link_clk_in = ~link_clk_in;

	pmbus_bundle_status_readback u_pmbus_bundle_status_readback (.*);
	rb_host u_rb_host (.link_clk_in(link_clk_in), .req_ready_in(req_ready_out), .resp_valid_in(resp_valid_out),
		.resp_len_in(resp_len_out), .resp_data_in(resp_data_out), .req_out(req_in), .cmd_out(cmd_code_in),
		.write_out(cmd_write_in), .wdata_out(wr_data_in));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [111:0] exp_tel();
		return {32'h0, vin_off_in ? 16'h0 : vin_in, temp_in, iout_off_in ? 16'h0 : iout_in,
			vout_off_in ? 16'h0 : vout_in, status_word_in};
	endfunction

	function automatic logic [111:0] exp_st(input logic ivc);
		return {56'h0, status_mfr_in, status_other_in, ivc, status_cml_in, status_temp_in, status_input_in,
			status_iout_in, status_vout_in};
	endfunction

	task automatic tally_and_finish();
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [111:0] got, input logic [111:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [7:0] c, input logic w, input logic [15:0] d);
		u_rb_host.xfer(c, w, d, len, data, ok);
		if (!ok) begin
			err_count++;
			$display("ERROR %0t: no answer", $time);
			tally_and_finish();
		end
	endtask

	task automatic core_edge();
		@(posedge clk_in);
		#1;
	endtask

	initial begin
		repeat (3) core_edge();
		rst_n_in = 1'b1;
		@(posedge link_clk_in);
		#1;
		link_rst_n_in = 1'b1;
		for (int i = 0; i < 6; i++) begin
			core_edge();
			{status_word_in, vout_in} = rnd();
			{iout_in, temp_in} = rnd();
			vin_in = 16'(rnd());
			// last pass: every value that can be disabled is off
			{vout_off_in, iout_off_in, vin_off_in} = (i == 5) ? 3'b111 : (i < 2) ? 3'b000 : 3'(rnd());
			status_cml_in = 7'h0;
			rd(rb_pkg::CMD_TELEM, 1'b0, 16'h0);
			chk(data, exp_tel());
			chk(112'(len), 112'he);
			chk(112'(resp_hit_out), 112'h1);
			core_edge();
			{status_vout_in, status_iout_in, status_input_in, status_temp_in} = rnd();
			{status_other_in, status_mfr_in, status_cml_in} = 23'(rnd());
			rd(rb_pkg::CMD_STATUS, 1'b0, 16'h0);
			chk(data, exp_st(1'b0));
		end
		rd(8'h99, 1'b0, 16'h0);
		chk(data, 112'h0);
		chk(112'({resp_hit_out, len}), 112'h0);
		// other cml sources quiet, so only the invalid command can raise the summary bit
		core_edge();
		status_word_in[1] = 1'b0;
		status_cml_in = 7'h0;
		rd(rb_pkg::CMD_TELEM, 1'b1, 16'(rnd()));
		chk(112'({resp_hit_out, len}), 112'h10);
		chk(112'({status_cml_out, status_byte_out[1], smbalert_n_out}), 112'h202);
		rd(rb_pkg::CMD_STATUS, 1'b1, 16'hffff);
		chk(112'({resp_hit_out, len}), 112'h10);
		rd(rb_pkg::CMD_STATUS, 1'b0, 16'h0);
		chk(data, exp_st(1'b1));
		rd(rb_pkg::CMD_TELEM, 1'b0, 16'h0);
		chk(data, exp_tel() | 112'h2);
		core_edge();
		clear_faults_in = 1'b1;
		core_edge();
		clear_faults_in = 1'b0;
		repeat (2) core_edge();
		chk(112'(smbalert_n_out), 112'h1);
		phase_word_in = {rnd(), rnd()};
		phase_fault_in = 4'h9;
		core_edge();
		phase_fault_in = 4'h0;
		ex = '{112'h4, 112'h4, 112'(phase_word_in[47:32]), 112'h0};
		for (int k = 0; k < 4; k++) begin
			core_edge();
			phase_sel_in = (k == 0) ? 8'hff : (k == 1) ? 8'h80 : (k == 2) ? 8'h02 : 8'h00;
			rd(rb_pkg::CMD_PHASE, 1'b0, 16'h0);
			chk(data, ex[k]);
		end
		chk(112'(phase_flags_out), 112'h4);
		core_edge();
		phase_sel_in = 8'hff;
		rd(rb_pkg::CMD_PHASE, 1'b1, 16'hfff0);
		rd(rb_pkg::CMD_PHASE, 1'b0, 16'h0);
		chk(data, 112'h0);
		chk(112'(phase_flags_out), 112'h0);
		tally_and_finish();
	end
endmodule

`default_nettype wire
